// ==== rtl/dqsps_consts.svh ====
`ifndef DQSPS_CONSTS_SVH
`define DQSPS_CONSTS_SVH
// ==========================================================
// constants
`define DQSPS_LOCK_CYCLES   9'h100
`define DQSPS_PINS_PER_EDGE 10
`define DQSPS_PHASE_W       8
`define DQSPS_PHASE_ZERO    8'h00
`define DQSPS_DELAY_W       8
`define DQSPS_DQ_W          32
`define DQSPS_MODE_X8       2'h0
`define DQSPS_MODE_X16      2'h1
`define DQSPS_MODE_X32      2'h2
`define DQSPS_MASK_X8       32'h0000_00ff
`define DQSPS_MASK_X16      32'h0000_ffff
`define DQSPS_MASK_X32      32'hffff_ffff
`endif

// ==== rtl/dqsps_pkg.sv ====
package dqsps_pkg;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    dqsps_w8,
    dqsps_w16,
    dqsps_w32
  } dqsps_width_type;
  typedef enum logic [1:0] {
    dqsps_idle,
    dqsps_measure,
    dqsps_locked
  } dqsps_state_type;
endpackage

// ==== rtl/dqsps_ref_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// carries the shared delay word from a reference circuit to its edge
interface dqsps_ref_if;
  logic [7:0] delay;
  logic       locked;
  modport ref_src (output delay, output locked);
  modport ref_dst (input delay, input locked);
endinterface
`default_nettype wire

// ==== rtl/dqsps_ref.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dqsps_consts.svh"
// ==========================================================
// phase reference: measures the reference period in system clocks
// over the lock interval and derives the delay for the wanted phase
module dqsps_ref
  import dqsps_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_ref_rise,
  input  wire logic [7:0] i_phase,
  dqsps_ref_if.ref_src    ref_out
);
  dqsps_state_type state_ff;
  logic [8:0]      ref_cnt_ff;
  logic [15:0]     per_cnt_ff;
  logic [15:0]     per_sum_ff;
  logic [7:0]      delay_ff;
  logic            locked_ff;
  logic [23:0]     prod;

  // period average is sum/256; delay = avg * phase / 256 (phase in 1/256 cycle)
  assign prod = per_sum_ff * i_phase;

  // lock sequence counts reference edges, never more than 256
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff   <= dqsps_idle;
      ref_cnt_ff <= 9'h000;
      per_cnt_ff <= 16'h0000;
      per_sum_ff <= 16'h0000;
    end else begin
      case (state_ff)
        dqsps_idle: begin
          if (i_ref_rise) begin
            state_ff   <= dqsps_measure;
            per_cnt_ff <= 16'h0001;
          end
        end
        dqsps_measure: begin
          if (i_ref_rise) begin
            per_sum_ff <= per_sum_ff + per_cnt_ff;
            per_cnt_ff <= 16'h0001;
            ref_cnt_ff <= ref_cnt_ff + 9'h001;
            if (ref_cnt_ff == `DQSPS_LOCK_CYCLES - 9'h001) begin
              state_ff <= dqsps_locked;
            end
          end else begin
            per_cnt_ff <= per_cnt_ff + 16'h0001;
          end
        end
        dqsps_locked: state_ff <= dqsps_locked;
        default:      state_ff <= dqsps_idle;
      endcase
    end
  end

  // delay word tracks the phase setting once locked
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      delay_ff <= 8'h00;
    end else if (state_ff == dqsps_locked) begin
      delay_ff <= prod[23:16];
    end
  end

  // valid waits one cycle for the first computed delay word, so no
  // capture is ever flagged while the delay still holds its reset value
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      locked_ff <= 1'b0;
    end else begin
      locked_ff <= (state_ff == dqsps_locked);
    end
  end

  assign ref_out.delay  = delay_ff;
  assign ref_out.locked = locked_ff;
endmodule
`default_nettype wire

// ==== rtl/dqsps_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dqsps_consts.svh"
// ==========================================================
// strobe phase-shift control, both device edges
//
// Contract
// - Each strobe pin gets its own delay stage that shifts the strobe into its data window.
// - Delayed strobes form a local strobe bus that clocks the data capture registers; the code clocks them on i_mclk, enabled by the strobe's rising edge.
// - Each reference circuit is fed by an outside reference clock at the strobe frequency.
// - The top reference sets one common delay on all ten top strobe pins.
// - The bottom reference sets one common delay on all ten bottom strobe pins.
// - Top and bottom phases are set independently.
// - Each reference reaches its setting within 256 reference clock cycles.
// - Strobe groups are split between top and bottom, up to eight narrow groups per edge; the code gives each edge ten groups, one per strobe pin.
// - Each group carries 8, 16 or 32 data bits with one strobe per group.
module dqsps_ctrl
  import dqsps_pkg::*;
#(
  parameter int PINS = `DQSPS_PINS_PER_EDGE,
  parameter int DQW  = `DQSPS_DQ_W
) (
  input  wire logic                    i_mclk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_ref_top,
  input  wire logic                    i_ref_bot,
  input  wire logic [7:0]              i_phase_top,
  input  wire logic [7:0]              i_phase_bot,
  input  wire dqsps_pkg::dqsps_width_type i_width,
  input  wire logic [PINS-1:0]         i_dqs_top,
  input  wire logic [PINS-1:0]         i_dqs_bot,
  input  wire logic [PINS*DQW-1:0]     i_dq_top,
  input  wire logic [PINS*DQW-1:0]     i_dq_bot,
  output logic [PINS*DQW-1:0]          o_q_top,
  output logic [PINS*DQW-1:0]          o_q_bot,
  output logic [PINS-1:0]              o_cap_top,
  output logic [PINS-1:0]              o_cap_bot,
  output logic [7:0]                   o_delay_top,
  output logic [7:0]                   o_delay_bot,
  output logic                         o_valid_top,
  output logic                         o_valid_bot
);
  // ==========================================================
  // synchronisers: every pin input passes two flops first
  // the data flops match the strobe flops, so a strobe edge and the
  // data that it qualifies stay aligned through the crossing
  logic [1:0]          ref_top_s_ff, ref_bot_s_ff;
  logic                ref_top_d_ff, ref_bot_d_ff;
  logic [PINS-1:0]     dqs_top_m_ff, dqs_top_s_ff, dqs_bot_m_ff, dqs_bot_s_ff;
  logic [PINS*DQW-1:0] dq_top_m_ff, dq_top_s_ff, dq_bot_m_ff, dq_bot_s_ff;

  // top reference clock comes from the system, sampled here
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ref_top_s_ff <= 2'h0;
      ref_top_d_ff <= 1'b0;
    end else begin
      ref_top_s_ff <= {ref_top_s_ff[0], i_ref_top};
      ref_top_d_ff <= ref_top_s_ff[1];
    end
  end

  // bottom reference clock, same treatment
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ref_bot_s_ff <= 2'h0;
      ref_bot_d_ff <= 1'b0;
    end else begin
      ref_bot_s_ff <= {ref_bot_s_ff[0], i_ref_bot};
      ref_bot_d_ff <= ref_bot_s_ff[1];
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      dqs_top_m_ff <= '0;
      dqs_top_s_ff <= '0;
      dqs_bot_m_ff <= '0;
      dqs_bot_s_ff <= '0;
    end else begin
      dqs_top_m_ff <= i_dqs_top;
      dqs_top_s_ff <= dqs_top_m_ff;
      dqs_bot_m_ff <= i_dqs_bot;
      dqs_bot_s_ff <= dqs_bot_m_ff;
    end
  end

  // data lanes: only the second flop is read, never the raw pins
  // the memory holds data steady around each strobe, so the word is
  // settled by the time the delayed strobe picks it up
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      dq_top_m_ff <= '0;
      dq_top_s_ff <= '0;
      dq_bot_m_ff <= '0;
      dq_bot_s_ff <= '0;
    end else begin
      dq_top_m_ff <= i_dq_top;
      dq_top_s_ff <= dq_top_m_ff;
      dq_bot_m_ff <= i_dq_bot;
      dq_bot_s_ff <= dq_bot_m_ff;
    end
  end

  // ==========================================================
  // two independent reference circuits
  // each edge locks on its own, so a missing reference on one edge
  // leaves the other edge working
  dqsps_ref_if top_if ();
  dqsps_ref_if bot_if ();

  // separate phase inputs per edge
  dqsps_ref u_ref_top (
    .i_mclk     (i_mclk),
    .i_resetn   (i_resetn),
    .i_ref_rise (ref_top_s_ff[1] & ~ref_top_d_ff),
    .i_phase    (i_phase_top),
    .ref_out    (top_if.ref_src)
  );
  dqsps_ref u_ref_bot (
    .i_mclk     (i_mclk),
    .i_resetn   (i_resetn),
    .i_ref_rise (ref_bot_s_ff[1] & ~ref_bot_d_ff),
    .i_phase    (i_phase_bot),
    .ref_out    (bot_if.ref_src)
  );

  // ==========================================================
  // per-pin delay lines: a tapped history of the sampled strobe
  // limitation: delay resolution is one system clock, 5 ns
  // trade-off: a shift register per pin costs flops but needs no
  // calibrated analog delay; the price is that a moved delay word can
  // clip or repeat one strobe pulse, so phase changes belong between bursts
  localparam int TAPS = 1 << `DQSPS_DELAY_W;
  logic [TAPS-1:0] hist_top_ff [PINS];
  logic [TAPS-1:0] hist_bot_ff [PINS];
  logic [PINS-1:0] strb_top, strb_bot;     // local strobe bus per edge
  logic [PINS-1:0] strb_top_d_ff, strb_bot_d_ff;
  logic [PINS-1:0] rise_top, rise_bot;     // first cycle of a delayed strobe
  logic [DQW-1:0]  wmask;

  // unused lanes of a narrow group read as zero
  // so a stale upper half never looks like fresh data
  always_comb begin
    case (i_width)
      dqsps_w8:  wmask = DQW'(`DQSPS_MASK_X8);
      dqsps_w16: wmask = DQW'(`DQSPS_MASK_X16);
      dqsps_w32: wmask = DQW'(`DQSPS_MASK_X32);
      default:   wmask = DQW'(`DQSPS_MASK_X32);
    endcase
  end

  for (genvar g = 0; g < PINS; g++) begin : g_pin
    // own delay stage per top strobe pin
    always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
        hist_top_ff[g] <= '0;
      end else begin
        hist_top_ff[g] <= {hist_top_ff[g][TAPS-2:0], dqs_top_s_ff[g]};
      end
    end

    // own delay stage per bottom strobe pin
    always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
        hist_bot_ff[g] <= '0;
      end else begin
        hist_bot_ff[g] <= {hist_bot_ff[g][TAPS-2:0], dqs_bot_s_ff[g]};
      end
    end

    // one common delay word per edge
    assign strb_top[g] = hist_top_ff[g][top_if.delay];
    assign strb_bot[g] = hist_bot_ff[g][bot_if.delay];
    assign rise_top[g] = strb_top[g] & ~strb_top_d_ff[g];
    assign rise_bot[g] = strb_bot[g] & ~strb_bot_d_ff[g];

    // top capture on the rising edge of the delayed strobe
    // a capture before lock still updates the data, but shows no pulse
    always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
        strb_top_d_ff[g]      <= 1'b0;
        o_q_top[g*DQW +: DQW] <= '0;
        o_cap_top[g]          <= 1'b0;
      end else begin
        strb_top_d_ff[g] <= strb_top[g];
        o_cap_top[g]     <= rise_top[g] & top_if.locked;
        if (rise_top[g]) begin
          o_q_top[g*DQW +: DQW] <= dq_top_s_ff[g*DQW +: DQW] & wmask;
        end
      end
    end

    // bottom capture, same scheme
    always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
        strb_bot_d_ff[g]      <= 1'b0;
        o_q_bot[g*DQW +: DQW] <= '0;
        o_cap_bot[g]          <= 1'b0;
      end else begin
        strb_bot_d_ff[g] <= strb_bot[g];
        o_cap_bot[g]     <= rise_bot[g] & bot_if.locked;
        if (rise_bot[g]) begin
          o_q_bot[g*DQW +: DQW] <= dq_bot_s_ff[g*DQW +: DQW] & wmask;
        end
      end
    end
  end

  // ==========================================================
  // status and delay words seen by the rest of the device
  // groups split across edges, one set of lanes per edge
  // data flagged valid only after lock
  assign o_valid_top = top_if.locked;
  assign o_valid_bot = bot_if.locked;
  assign o_delay_top = top_if.delay;
  assign o_delay_bot = bot_if.delay;
endmodule
`default_nettype wire

// ==== tb/dqsps_ctrl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the strobe phase-shift control
module dqsps_ctrl_monitor #(
  parameter int PINS = 10,
  parameter int DQW  = 32
) (
  input wire logic            i_mclk,
  input wire logic            i_resetn,
  input wire logic [7:0]      i_phase_top,
  input wire logic [7:0]      i_phase_bot,
  input wire logic [PINS-1:0] o_cap_top,
  input wire logic [PINS-1:0] o_cap_bot,
  input wire logic [7:0]      o_delay_top,
  input wire logic [7:0]      o_delay_bot,
  input wire logic            o_valid_top,
  input wire logic            o_valid_bot
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // ==========================================================
  // capture gating and lock
  a_cap_top_gated: assert property (o_cap_top != '0 |-> o_valid_top)
    else $error("top capture before lock");
  a_cap_bot_gated: assert property (o_cap_bot != '0 |-> o_valid_bot)
    else $error("bottom capture before lock");
  a_valid_top_held: assert property (o_valid_top |=> o_valid_top)
    else $error("top lock dropped");
  a_valid_bot_held: assert property (o_valid_bot |=> o_valid_bot)
    else $error("bottom lock dropped");
  // a full lock needs thousands of cycles, so eight is a safe floor
  a_reset_unlocked: assert property ($rose(i_resetn) |-> !(o_valid_top || o_valid_bot) [*8])
    else $error("lock reported right after reset");
  // ==========================================================
  // delay words and strobe bus
  a_zero_top: assert property ((o_valid_top && i_phase_top == 8'h00) [*3] |-> o_delay_top == 8'h00)
    else $error("top delay not zero at zero phase");
  a_zero_bot: assert property ((o_valid_bot && i_phase_bot == 8'h00) [*3] |-> o_delay_bot == 8'h00)
    else $error("bottom delay not zero at zero phase");
  a_cap_pulse: assert property (o_cap_top[0] |=> !o_cap_top[0])
    else $error("capture strobe longer than one cycle");
  c_lock: cover property ($rose(o_valid_top));
  c_cap_top: cover property (o_cap_top == '1);
  c_cap_bot: cover property (o_cap_bot == '1);
endmodule
bind dqsps_ctrl dqsps_ctrl_monitor #(.PINS(PINS), .DQW(DQW)) mon_u (.i_mclk, .i_resetn,
  .i_phase_top, .i_phase_bot, .o_cap_top, .o_cap_bot, .o_delay_top, .o_delay_bot,
  .o_valid_top, .o_valid_bot);
`default_nettype wire

// ==== tb/dqsps_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// memory side: reference clock, read strobes and data
module dqsps_mem_model #(
  parameter int PINS = 10,
  parameter int DQW  = 32
) (
  input  wire logic           i_rd,
  input  wire logic [DQW-1:0] i_pat,
  output logic                o_ref,
  output logic [PINS-1:0]     o_dqs,
  output logic [PINS*DQW-1:0] o_dq_top,
  output logic [PINS*DQW-1:0] o_dq_bot
);
  logic rd_q  = 1'b0;
  logic ref_q = 1'b0;
  // free-running board reference at the strobe rate, one driver only
  always #24 ref_q = ~ref_q;
  assign o_ref = ref_q;
  // burst gate moves only while the strobe is low, so no runt pulses
  always @(negedge ref_q) rd_q <= i_rd;
  assign o_dqs = {PINS{rd_q & ref_q}};
  // outside a burst the data lines show the inverse, never a held value
  assign o_dq_top = {PINS{rd_q ? i_pat : ~i_pat}};
  assign o_dq_bot = ~o_dq_top;
endmodule
`default_nettype wire

// ==== tb/dqsps_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display("FAIL %0t %h %h", $time, a, b); end end
module dqsps_ctrl_tb;
  import dqsps_pkg::*;
  localparam int PINS = 10;
  localparam int DQW  = 32;
  logic                   i_mclk = 1'b0;
  logic                   i_resetn = 1'b0;
  logic [7:0]             ph_top = 8'h40;
  logic [7:0]             ph_bot = 8'h40;
  dqsps_width_type        width = dqsps_w32;
  logic                   rd = 1'b1;
  logic [DQW-1:0]         pat = 32'ha5c3_9e17;
  logic                   ref_clk;
  logic [PINS-1:0]        dqs;
  logic [PINS*DQW-1:0]    dq_top, dq_bot, q_top, q_bot;
  logic [PINS-1:0]        cap_top, cap_bot;
  logic [7:0]             dly_top, dly_bot;
  logic                   vld_top, vld_bot;
  int                     fail_count = 0;
  int                     checked = 0;
  int                     cycles = 0;
  dqsps_mem_model #(.PINS(PINS), .DQW(DQW)) mem_u (.i_rd(rd), .i_pat(pat), .o_ref(ref_clk),
    .o_dqs(dqs), .o_dq_top(dq_top), .o_dq_bot(dq_bot));
  dqsps_ctrl #(.PINS(PINS), .DQW(DQW)) dut_u (.i_mclk, .i_resetn, .i_ref_top(ref_clk),
    .i_ref_bot(ref_clk), .i_phase_top(ph_top), .i_phase_bot(ph_bot), .i_width(width),
    .i_dqs_top(dqs), .i_dqs_bot(dqs), .i_dq_top(dq_top), .i_dq_bot(dq_bot), .o_q_top(q_top),
    .o_q_bot(q_bot), .o_cap_top(cap_top), .o_cap_bot(cap_bot), .o_delay_top(dly_top),
    .o_delay_bot(dly_bot), .o_valid_top(vld_top), .o_valid_bot(vld_bot));
  // 200 MHz system clock
  always #2.5 i_mclk = ~i_mclk;
  // ==========================================================
  // hang guard: two locks take about 5000 cycles
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // delay word may round either way because the period is averaged
  function automatic bit dly_ok(logic [7:0] d, logic [7:0] p);
    int e = (48 * p) / (5 * 256);
    return d >= e && d <= e + 1;
  endfunction
  // ==========================================================
  // reset, then lock takes 256 reference periods of 9.6 cycles
  task automatic t_lock;
    int n = 0;
    @(posedge i_mclk);
    i_resetn <= 1'b0;
    repeat (20) @(posedge i_mclk);
    i_resetn <= 1'b1;
    while (vld_top !== 1'b1 && n < 3000) begin
      @(negedge i_mclk);
      n++;
    end
    `CHK(n >= 2448 && n <= 2484, 1'b1)
    `CHK(vld_bot, 1'b1)
  endtask
  // top and bottom phases moved apart, including both extremes
  task automatic t_phase;
    logic [7:0] pt [3] = '{8'h40, 8'h00, 8'hff};
    logic [7:0] pb [3] = '{8'h33, 8'hff, 8'h00};
    for (int k = 0; k < 3; k++) begin
      @(posedge i_mclk);
      ph_top <= pt[k];
      ph_bot <= pb[k];
      repeat (8) @(negedge i_mclk);
      `CHK(dly_ok(dly_top, pt[k]), 1'b1)
      `CHK(dly_ok(dly_bot, pb[k]), 1'b1)
    end
  endtask
  // first capture of a burst in every bus width, all pins together
  task automatic t_capture;
    dqsps_width_type w [3] = '{dqsps_w8, dqsps_w16, dqsps_w32};
    logic [DQW-1:0] m [3] = '{32'h0000_00ff, 32'h0000_ffff, 32'hffff_ffff};
    int n;
    for (int k = 0; k < 3; k++) begin
      @(posedge i_mclk);
      ph_top <= 8'h40;
      ph_bot <= 8'h40;
      width <= w[k];
      rd <= 1'b0;
      repeat (20) @(posedge i_mclk);
      rd <= 1'b1;
      n = 0;
      while (cap_top === '0 && n < 40) begin
        @(negedge i_mclk);
        n++;
      end
      `CHK(cap_top, {PINS{1'b1}})
      `CHK(cap_bot, {PINS{1'b1}})
      `CHK({q_top[9*DQW+:DQW], q_top[0+:DQW]}, {2{pat & m[k]}})
      `CHK({q_bot[9*DQW+:DQW], q_bot[0+:DQW]}, {2{~pat & m[k]}})
    end
  endtask
  // strobes run through the first lock; the second lock is a reset in mid-run
  initial begin
    t_lock();
    t_phase();
    t_capture();
    t_lock();
    complete_run();
  end
endmodule
`default_nettype wire
